// [lgp_device.sv]
// Device end: segment registers, global control and clock select
`timescale 1ns/1ps
// Overview of operation
// - Per-channel seventh segment at 0x0E plus 16n.
// - Per-channel eighth segment at 0x0F plus 16n.
// - Segment bit 6 is sign, one positive.
// - Global bit 7: one single rail.
// - Global bit 6 sends all ones on loss.
// - Global bit 5: one receive on falling edge.
// - Global bit 4: one transmit samples rising.
// - Global bit 3: one means active low data.
// - Global bit 1 gates all interrupts.
// - Interrupt needs channel enable and global enable; no channel enable here, IRQ is any CH_IRQ_PEND bit gated by global bit 1.
// - Host holds reset bit over ten microseconds.
// - Reset bit holds core, keeps registers.
// - Clock select bits retune synthesizer output.
// - Rate change write alters no other bits.
// - Clock select is upper and lower parts.
// - Upper-only change needs one write.
// - Both parts change in two writes.
module lgp_device
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Register bus
	lgp_bus_if.dev BUS,
	// Channel events
	input wire logic [lgp_pkg::NUM_CH-1:0] CH_IRQ_PEND,
	input wire logic [lgp_pkg::NUM_CH-1:0] CH_SIGNAL_LOSS,
	// Global settings
	output logic RAIL_MODE_SELECT,
	output logic RX_CLOCK_EDGE_SELECT,
	output logic TX_CLOCK_EDGE_SELECT,
	output logic DATA_POLARITY_SELECT,
	output logic CORE_RESET,
	output logic [lgp_pkg::NUM_CH-1:0] SEND_ALL_ONES,
	output logic IRQ,
	// Synthesizer control
	output logic [2:0] SYNTH_INPUT_SELECT,
	output logic MASTER_RATE_SELECT,
	output logic [2:0] SYNTH_INPUT_SELECT_LOW,
	output logic LCV_OVERFLOW_SELECT,
	// Pulse segments, sign in bit 6
	output logic [lgp_pkg::NUM_CH-1:0] SEG7_SIGN,
	output logic [lgp_pkg::NUM_CH-1:0] SEG8_SIGN,
	output logic [lgp_pkg::NUM_CH*6-1:0] SEG7_MAG,
	output logic [lgp_pkg::NUM_CH*6-1:0] SEG8_MAG
);
	import lgp_pkg::*;

	// Bus decode
	logic wr;
	logic rd;
	logic hit_glb;
	logic hit_cs;
	logic hit_seg7;
	logic hit_seg8;
	logic [2:0] ch_sel;
	logic [NUM_CH-1:0] wr7;
	logic [NUM_CH-1:0] wr8;
	logic [DATA_W-1:0] seg7_w [NUM_CH];
	logic [DATA_W-1:0] seg8_w [NUM_CH];
	// Global control and clock select
	logic [DATA_W-1:0] glb_r, glb_nxt;
	logic [DATA_W-1:0] cs_r, cs_nxt;
	// Read data
	logic [DATA_W-1:0] rd_r, rd_nxt;
	// Channel events
	logic [NUM_CH-1:0] loss_s1_r, loss_s2_r;
	logic [NUM_CH-1:0] ones_r, ones_nxt;
	logic irq_r, irq_nxt;
	logic core_run;

	assign wr = BUS.cs && BUS.we;
	assign rd = BUS.cs && !BUS.we;
	// Segments live only in the lower half of the map
	assign hit_seg7 = !BUS.addr[7] && BUS.addr[3:0] == OFS_SEG7;
	assign hit_seg8 = !BUS.addr[7] && BUS.addr[3:0] == OFS_SEG8;
	assign hit_glb = BUS.addr == ADDR_GLOBAL;
	assign hit_cs = BUS.addr == ADDR_SYNTH_INPUT_SELECT;
	assign ch_sel = BUS.addr[6:4];
	assign core_run = !glb_r[G_SRST];

	// One segment pair per channel
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : ch
			assign wr7[g] = wr && hit_seg7 && ch_sel == 3'(g);
			assign wr8[g] = wr && hit_seg8 && ch_sel == 3'(g);
			lgp_seg_chan i_lgp_seg_chan (
				.clk(CLK_SYS),
				.rst(RST),
				.wr7(wr7[g]),
				.wr8(wr8[g]),
				.wdata(BUS.wdata),
				.seg7(seg7_w[g]),
				.seg8(seg8_w[g])
			);
			assign SEG7_SIGN[g] = seg7_w[g][SEG_SIGN];
			assign SEG8_SIGN[g] = seg8_w[g][SEG_SIGN];
			assign SEG7_MAG[g*6 +: 6] = seg7_w[g][5:0];
			assign SEG8_MAG[g*6 +: 6] = seg8_w[g][5:0];
		end
	endgenerate

	// Software reset leaves the global and clock select registers untouched
	always_comb
	begin
		glb_nxt = glb_r;
		cs_nxt = cs_r;
		if (wr && hit_glb)
			glb_nxt = BUS.wdata & GLOBAL_MASK;
		// Whole byte stored; host splits updates into the two parts
		if (wr && hit_cs)
			cs_nxt = BUS.wdata;
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			glb_r <= GLOBAL_RST;
			cs_r <= SYNTH_INPUT_SELECT_RST;
		end
		else
		begin
			glb_r <= glb_nxt;
			cs_r <= cs_nxt;
		end
	end

	// Read data is zero whenever no read is under way
	always_comb
	begin
		rd_nxt = '0;
		if (rd)
		begin
			// Unmapped addresses fall through and read zero
			if (hit_glb)
				rd_nxt = glb_r;
			else if (hit_cs)
				rd_nxt = cs_r;
			else if (hit_seg7)
				rd_nxt = seg7_w[ch_sel] & SEG_MASK;
			else if (hit_seg8)
				rd_nxt = seg8_w[ch_sel] & SEG_MASK;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			rd_r <= '0;
		else
			rd_r <= rd_nxt;
	end

	// Loss inputs are asynchronous: two flops before any logic
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			loss_s1_r <= '0;
			loss_s2_r <= '0;
		end
		else
		begin
			loss_s1_r <= CH_SIGNAL_LOSS;
			loss_s2_r <= loss_s1_r;
		end
	end

	// Substitution and interrupt held off while the core is in reset
	always_comb
	begin
		ones_nxt = '0;
		irq_nxt = 1'b0;
		if (core_run && glb_r[G_AUTO1])
			ones_nxt = loss_s2_r;
		if (core_run && glb_r[G_GIE])
			irq_nxt = |CH_IRQ_PEND;
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			ones_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			ones_r <= ones_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Outputs straight from flops, no decode glitches
	assign BUS.rdata = rd_r;
	assign RAIL_MODE_SELECT = glb_r[G_RAIL];
	assign RX_CLOCK_EDGE_SELECT = glb_r[G_RXEDGE];
	assign TX_CLOCK_EDGE_SELECT = glb_r[G_TXEDGE];
	assign DATA_POLARITY_SELECT = glb_r[G_POL];
	assign CORE_RESET = glb_r[G_SRST];
	assign SEND_ALL_ONES = ones_r;
	assign IRQ = irq_r;
	assign LCV_OVERFLOW_SELECT = cs_r[7];
	assign SYNTH_INPUT_SELECT = cs_r[6:4];
	assign MASTER_RATE_SELECT = cs_r[CS_UP_LO];
	assign SYNTH_INPUT_SELECT_LOW = cs_r[CS_LO_HI:0];
endmodule

// [lgp_pkg.sv]
// Shared constants and types for the line interface register bank
package lgp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_CH = 8;
	localparam logic [3:0] OFS_SEG7 = 4'he;
	localparam logic [3:0] OFS_SEG8 = 4'hf;
	localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 8'h80;
	localparam logic [ADDR_W-1:0] ADDR_SYNTH_INPUT_SELECT = 8'h81;
	localparam logic [DATA_W-1:0] GLOBAL_RST = 8'h00;
	localparam logic [DATA_W-1:0] SYNTH_INPUT_SELECT_RST = 8'h00;
	localparam logic [DATA_W-1:0] SEG_RST = 8'h00;
	localparam logic [DATA_W-1:0] SEG_MASK = 8'h7f;
	localparam logic [DATA_W-1:0] GLOBAL_MASK = 8'hfb;
	localparam int SEG_SIGN = 6;
	localparam int G_RAIL = 7;
	localparam int G_AUTO1 = 6;
	localparam int G_RXEDGE = 5;
	localparam int G_TXEDGE = 4;
	localparam int G_POL = 3;
	localparam int G_GIE = 1;
	localparam int G_SRST = 0;
	localparam int CS_UP_LO = 3;
	localparam int CS_LO_HI = 2;
	localparam int CLK_HZ = 10000000;
	localparam int SRST_HOLD_NS = 10000;
	// Hold strictly longer than the minimum time
	localparam int SRST_HOLD_CYC = (SRST_HOLD_NS * (CLK_HZ / 1000000)) / 1000 + 1;
	localparam int SRST_CNT_W = 8;
	typedef enum logic [1:0] {LGP_OP_WR, LGP_OP_RD, LGP_OP_SRST} lgp_op_t;
endpackage

// [lgp_bus_if.sv]
// Microprocessor bus between host and register bank
`timescale 1ns/1ps
interface lgp_bus_if;
	logic cs;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev (input cs, input we, input addr, input wdata, output rdata);
	modport host (output cs, output we, output addr, output wdata,
		input rdata);
endinterface

// [lgp_seg_chan.sv]
// One channel's seventh and eighth pulse segment registers
`timescale 1ns/1ps
module lgp_seg_chan
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr7,
	input wire logic wr8,
	input wire logic [lgp_pkg::DATA_W-1:0] wdata,
	output logic [lgp_pkg::DATA_W-1:0] seg7,
	output logic [lgp_pkg::DATA_W-1:0] seg8
);
	import lgp_pkg::*;
	logic [DATA_W-1:0] seg7_r, seg7_nxt, seg8_r, seg8_nxt;
	always_comb
	begin
		seg7_nxt = seg7_r;
		seg8_nxt = seg8_r;
		if (wr7)
			seg7_nxt = wdata & SEG_MASK;
		if (wr8)
			seg8_nxt = wdata & SEG_MASK;
	end
	// Register bits survive a software reset, so only RST clears them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			seg7_r <= SEG_RST;
			seg8_r <= SEG_RST;
		end
		else
		begin
			seg7_r <= seg7_nxt;
			seg8_r <= seg8_nxt;
		end
	end
	assign seg7 = seg7_r;
	assign seg8 = seg8_r;
endmodule

// [lgp_host.sv]
// Host end: register writes, reads and timed software reset
`timescale 1ns/1ps
module lgp_host
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Command port
	input wire logic REQ,
	input wire lgp_pkg::lgp_op_t OP,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	output logic BUSY,
	output logic DONE,
	output logic [7:0] RDATA,
	// Register bus
	lgp_bus_if.host BUS
);
	import lgp_pkg::*;
	typedef enum {S_IDLE, S_WR, S_WR2, S_RD, S_RDW, S_SRST, S_SCLR} lgp_hst_t;
	lgp_hst_t st_r, st_nxt;
	logic cs_r, cs_nxt, we_r, we_nxt, done_r, done_nxt;
	logic [7:0] a_r, a_nxt, d_r, d_nxt, d2_r, d2_nxt, rd_r, rd_nxt;
	logic [7:0] shadow_r, shadow_nxt;
	logic [SRST_CNT_W-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;

	always_comb
	begin
		st_nxt = st_r;
		cs_nxt = 1'b0;
		we_nxt = 1'b0;
		done_nxt = 1'b0;
		a_nxt = a_r;
		d_nxt = d_r;
		d2_nxt = d2_r;
		rd_nxt = rd_r;
		shadow_nxt = shadow_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			S_IDLE:
				if (REQ)
				begin
					a_nxt = ADDR;
					unique case (OP)
						LGP_OP_RD:
						begin
							cs_nxt = 1'b1;
							st_nxt = S_RD;
						end
						LGP_OP_SRST:
						begin
							a_nxt = ADDR_GLOBAL;
							// Other global bits ride along from WDATA
							d_nxt = WDATA;
							d_nxt[G_SRST] = 1'b1;
							cs_nxt = 1'b1;
							we_nxt = 1'b1;
							cnt_nxt = SRST_CNT_W'(SRST_HOLD_CYC);
							st_nxt = S_SRST;
						end
						default:
						begin
							cs_nxt = 1'b1;
							we_nxt = 1'b1;
							st_nxt = S_WR;
							d_nxt = WDATA;
							// Both parts changing: split into two writes
							if (ADDR == ADDR_SYNTH_INPUT_SELECT
								&& WDATA[7:3] != shadow_r[7:3]
								&& WDATA[2:0] != shadow_r[2:0])
							begin
								d_nxt = {WDATA[7:3], shadow_r[2:0]};
								d2_nxt = WDATA;
								st_nxt = S_WR2;
							end
							if (ADDR == ADDR_SYNTH_INPUT_SELECT)
								shadow_nxt = WDATA;
						end
					endcase
				end
			S_WR2:
			begin
				cs_nxt = 1'b1;
				we_nxt = 1'b1;
				d_nxt = d2_r;
				st_nxt = S_WR;
			end
			S_WR:
			begin
				done_nxt = 1'b1;
				st_nxt = S_IDLE;
			end
			S_RD:
				st_nxt = S_RDW;
			S_RDW:
			begin
				rd_nxt = BUS.rdata;
				done_nxt = 1'b1;
				st_nxt = S_IDLE;
			end
			S_SRST:
				if (cnt_r == '0)
				begin
					d_nxt[G_SRST] = 1'b0;
					cs_nxt = 1'b1;
					we_nxt = 1'b1;
					st_nxt = S_SCLR;
				end
				else
					cnt_nxt = cnt_r - 1'b1;
			S_SCLR:
			begin
				done_nxt = 1'b1;
				st_nxt = S_IDLE;
			end
		endcase
		busy_nxt = st_nxt != S_IDLE;
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			st_r <= S_IDLE;
			cs_r <= 1'b0;
			we_r <= 1'b0;
			done_r <= 1'b0;
			a_r <= 8'h00;
			d_r <= 8'h00;
			d2_r <= 8'h00;
			rd_r <= 8'h00;
			shadow_r <= SYNTH_INPUT_SELECT_RST;
			cnt_r <= '0;
			busy_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cs_r <= cs_nxt;
			we_r <= we_nxt;
			done_r <= done_nxt;
			a_r <= a_nxt;
			d_r <= d_nxt;
			d2_r <= d2_nxt;
			rd_r <= rd_nxt;
			shadow_r <= shadow_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign BUS.cs = cs_r;
	assign BUS.we = we_r;
	assign BUS.addr = a_r;
	assign BUS.wdata = d_r;
	assign BUSY = busy_r;
	assign DONE = done_r;
	assign RDATA = rd_r;
endmodule

// [lgp_bus_monitor.sv]
// Bus checker for the register bank interface
`timescale 1ns/1ps
module lgp_bus_monitor
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Register bus
	input wire logic cs,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	import lgp_pkg::*;
	logic [7:0] seg_r [16];
	logic [7:0] g_r;
	logic [7:0] c_r;
	logic [7:0] hold_r;
	logic rd;
	logic wr;
	logic seg;
	logic [3:0] ix;
	assign rd = cs && !we;
	assign wr = cs && we;
	assign seg = !addr[7] && addr[3:1] == 3'h7;
	assign ix = {addr[6:4], addr[0]};
	// Shadow copies, so read data is judged against what was written
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 0; i < 16; i++)
				seg_r[i] <= 8'h00;
			g_r <= 8'h00;
			c_r <= 8'h00;
			hold_r <= 8'h00;
		end
		else
		begin
			hold_r <= g_r[0] ? hold_r + {7'h00, hold_r != 8'hff} : 8'h00;
			if (wr && seg)
				seg_r[ix] <= wdata & SEG_MASK;
			if (wr && addr == ADDR_GLOBAL)
				g_r <= wdata & GLOBAL_MASK;
			if (wr && addr == ADDR_SYNTH_INPUT_SELECT)
				c_r <= wdata;
		end
	end
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	a_seg_read_back: assert property (rd && seg |=>
		rdata == seg_r[$past(ix)]) else $error("segment read wrong");
	a_seg_top_zero: assert property (rd && seg |=> !rdata[7])
		else $error("segment bit 7 not zero");
	a_global_read: assert property (rd && addr == ADDR_GLOBAL |=>
		rdata == g_r) else $error("global read wrong");
	a_synth_input_select_read: assert property (rd && addr == ADDR_SYNTH_INPUT_SELECT |=>
		rdata == c_r) else $error("clock select read wrong");
	a_unmapped_zero: assert property (rd && !seg &&
		addr != ADDR_GLOBAL && addr != ADDR_SYNTH_INPUT_SELECT |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_idle_rdata_zero: assert property (!rd |=>
		rdata == 8'h00) else $error("read data without read");
	a_split_write: assert property (wr && addr == ADDR_SYNTH_INPUT_SELECT |->
		wdata[7:3] == c_r[7:3] || wdata[2:0] == c_r[2:0])
		else $error("both clock select parts changed");
	a_reset_hold: assert property (wr && addr == ADDR_GLOBAL &&
		g_r[0] && !wdata[0] |-> hold_r >= 8'(SRST_HOLD_CYC - 1))
		else $error("software reset held too short");
	c_seg_read: cover property (rd && seg);
	c_synth_input_select_write: cover property (wr && addr == ADDR_SYNTH_INPUT_SELECT);
	c_reset_end: cover property ($fell(g_r[0]));
endmodule

// [testbench.sv]
// Testbench joining host and device ends of the register bank
`timescale 1ns/1ps
module testbench;
	import lgp_pkg::*;
	logic clk, rst, req, busy, done, rail, rxe, txe, pol, core, irq;
	logic mrate, lcv;
	lgp_op_t op;
	logic [7:0] a_q, d_q, rdat, pend, loss, ones, s7s, s8s;
	logic [2:0] syn, clo;
	logic [47:0] s7m, s8m;
	int n_mismatch = 0;
	int checks_done = 0;
	lgp_bus_if bus();
	lgp_device i_lgp_device (.CLK_SYS(clk), .RST(rst), .BUS(bus),
		.CH_IRQ_PEND(pend), .CH_SIGNAL_LOSS(loss), .RAIL_MODE_SELECT(rail),
		.RX_CLOCK_EDGE_SELECT(rxe), .TX_CLOCK_EDGE_SELECT(txe),
		.DATA_POLARITY_SELECT(pol), .CORE_RESET(core), .SEND_ALL_ONES(ones),
		.IRQ(irq), .SYNTH_INPUT_SELECT(syn), .MASTER_RATE_SELECT(mrate),
		.SYNTH_INPUT_SELECT_LOW(clo), .LCV_OVERFLOW_SELECT(lcv), .SEG7_SIGN(s7s),
		.SEG8_SIGN(s8s), .SEG7_MAG(s7m), .SEG8_MAG(s8m));
	lgp_host i_lgp_host (.CLK_SYS(clk), .RST(rst), .REQ(req), .OP(op),
		.ADDR(a_q), .WDATA(d_q), .BUSY(busy), .DONE(done), .RDATA(rdat),
		.BUS(bus));
	lgp_bus_monitor i_lgp_bus_monitor (.CLK_SYS(clk), .RST(rst),
		.cs(bus.cs), .we(bus.we), .addr(bus.addr), .wdata(bus.wdata),
		.rdata(bus.rdata));
	initial
	begin
		clk = 1'b0;
		forever
			#50 clk = ~clk;
	end
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Waits are bounded, so a dead handshake cannot hang the run
	task automatic cmd(input lgp_op_t o, input logic [7:0] a, d);
		int n;
		@(posedge clk);
		req <= 1'b1;
		op <= o;
		a_q <= a;
		d_q <= d;
		@(posedge clk);
		req <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (done !== 1'b1 && n < 300);
		chk(done, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, exp);
		cmd(LGP_OP_RD, a, 8'h00);
		chk(rdat, exp);
	endtask
	function automatic logic [7:0] sv(input int c, k);
		return 8'(8'h93 + c * 37 + k * 11);
	endfunction
	task automatic t_seg;
		logic [7:0] v, w;
		for (int c = 0; c < 8; c++)
		begin
			cmd(LGP_OP_WR, {c[3:0], OFS_SEG7}, sv(c, 0));
			cmd(LGP_OP_WR, {c[3:0], OFS_SEG8}, sv(c, 1));
		end
		for (int c = 0; c < 8; c++)
		begin
			v = sv(c, 0);
			w = sv(c, 1);
			rd({c[3:0], OFS_SEG7}, v & 8'h7f);
			rd({c[3:0], OFS_SEG8}, w & 8'h7f);
			chk({s7s[c], s7m[6*c+:6]}, v[6:0]);
			chk({s8s[c], s8m[6*c+:6]}, w[6:0]);
		end
	endtask
	task automatic t_global;
		rd(ADDR_GLOBAL, 8'h00);
		cmd(LGP_OP_WR, ADDR_GLOBAL, 8'hfe);
		rd(ADDR_GLOBAL, 8'hfa);
		chk({rail, rxe, txe, pol}, 4'hf);
		@(posedge clk);
		pend <= 8'h10;
		loss <= 8'h21;
		repeat (6) @(posedge clk);
		chk({irq, ones}, 9'h121);
		cmd(LGP_OP_WR, ADDR_GLOBAL, 8'h00);
		repeat (3) @(posedge clk);
		chk({irq, ones, rail, rxe, txe, pol}, 13'h0);
	endtask
	task automatic t_srst;
		cmd(LGP_OP_WR, ADDR_GLOBAL, 8'h42);
		fork
			cmd(LGP_OP_SRST, ADDR_GLOBAL, 8'h42);
			begin
				repeat (50) @(posedge clk);
				chk({core, irq, ones}, 10'h200);
			end
		join
		rd(ADDR_GLOBAL, 8'h42);
		chk({core, irq, ones}, 10'h121);
	endtask
	task automatic t_synth_input_select;
		cmd(LGP_OP_WR, ADDR_SYNTH_INPUT_SELECT, 8'h78);
		chk({syn, mrate, clo}, 7'h78);
		cmd(LGP_OP_WR, ADDR_SYNTH_INPUT_SELECT, 8'h85);
		chk({lcv, syn, mrate, clo}, 8'h85);
		rd(ADDR_SYNTH_INPUT_SELECT, 8'h85);
		rd(8'h82, 8'h00);
		rd(8'h4d, 8'h00);
		rd(8'h8e, 8'h00);
	endtask
	initial
	begin
		rst = 1'b1;
		req = 1'b0;
		op = LGP_OP_WR;
		a_q = 8'h00;
		d_q = 8'h00;
		pend = 8'h00;
		loss = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_global();
		t_seg();
		t_srst();
		t_synth_input_select();
		complete_run();
	end
	initial
	begin
		#300000;
		n_mismatch++;
		complete_run();
	end
endmodule
